/* hw/cba_pkg.sv */
package cba_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;            // Node clock period
  localparam int BIT_NS = 1000;          // Bit time at 1 Mb/s
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int SAMPLE_CYC = BIT_CYC / 2;
  localparam logic [4:0] PH_LAST = 5'(BIT_CYC - 1);
  localparam logic [4:0] PH_SAMPLE = 5'(SAMPLE_CYC);

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int ID_W = 11;              // Arbitration identifier
  localparam int DATA_W = 8;             // One payload byte
  localparam int BODY_W = ID_W + DATA_W;
  localparam int FRAME_BITS = 1 + BODY_W; // Start bit, id, data
  localparam int IDLE_BITS = 11;         // Recessive bits for bus free
  localparam logic [4:0] BIT_LAST = 5'(FRAME_BITS - 1);
  localparam logic [4:0] ARB_END = 5'(ID_W);
  localparam logic [4:0] IDLE_LAST = 5'(IDLE_BITS - 1);
  localparam logic [4:0] IDX_ONE = 5'h01;

  // Bus levels
  localparam logic DOM = 1'b0;
  localparam logic REC = 1'b1;

  // Transmit buffer depth
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [DATA_W-1:0] data;
  } cba_frame_t;

  typedef enum {
    ST_WAIT_IDLE,
    ST_IDLE,
    ST_FRAME
  } cba_state_t;

endpackage

/* hw/cba_buf.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Small valid/ready buffer
// ------------------------------------------------------------------
module cba_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];   // Storage words
  logic [AW-1:0] wr, next_wr;  // Write slot
  logic [AW-1:0] rd, next_rd;  // Read slot
  logic [AW:0] cnt, next_cnt;  // Words held
  logic push, pop;

  // Honest flags straight from the count
  assign in_ready = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_wr = wr;
    next_rd = rd;
    if (push) begin
      next_wr = (wr == AW'(DEPTH - 1)) ? '0 : wr + AW'(1);
    end
    if (pop) begin
      next_rd = (rd == AW'(DEPTH - 1)) ? '0 : rd + AW'(1);
    end
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr <= '0;
      rd <= '0;
      cnt <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
      cnt <= next_cnt;
    end
  end

  // Storage has no reset; it is only read behind out_valid
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr] <= in_data;
    end
  end

endmodule

`default_nettype wire

/* hw/cba_node.sv */
`timescale 1ns/1ps
`default_nettype none

module cba_node (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Frames to send
  input wire logic tx_valid,
  output logic tx_ready,
  input wire cba_pkg::cba_frame_t tx_frame,
  // Acceptance filter
  input wire logic [cba_pkg::ID_W-1:0] acc_id,
  input wire logic [cba_pkg::ID_W-1:0] acc_mask,
  // Received frames
  output logic rx_valid,
  output cba_pkg::cba_frame_t rx_frame,
  // Status
  output logic tx_done,
  output logic arb_lost,
  output logic bus_idle,
  // Transceiver pins
  output logic can_tx,
  input wire logic can_rx
);
  import cba_pkg::*;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  logic buf_valid;          // A frame is pending
  logic buf_pop;            // Frame sent, release it
  cba_frame_t buf_data;     // Pending frame

  // Frames stay here across lost arbitration
  cba_buf #(
    .W(BODY_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_frame),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  // ----------------------------------------------------------------
  // Receive pin synchroniser
  // ----------------------------------------------------------------
  logic rx_m;   // First stage, metastable
  logic rx_q;   // Settled bus level
  logic rx_d;   // Delayed copy for edges
  logic fall;   // Recessive to dominant

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_m <= REC;
      rx_q <= REC;
      rx_d <= REC;
    end else begin
      rx_m <= can_rx;
      rx_q <= rx_m;
      rx_d <= rx_q;
    end
  end

  assign fall = (rx_d == REC) && (rx_q == DOM);

  // ----------------------------------------------------------------
  // Bit engine state
  // ----------------------------------------------------------------
  cba_state_t st, next_st;
  logic [4:0] ph, next_ph;          // Clock count within a bit
  logic [4:0] idx, next_idx;        // Bit or idle-bit number
  logic next_tx;                    // Level driven on the pin
  logic tx_active, next_txact;      // Still contending / sending
  logic [BODY_W-1:0] tx_shift, next_shift;
  logic [FRAME_BITS-1:0] rx_shift, next_rxs;
  logic next_lost, next_done, next_rxv;
  cba_frame_t next_rxf;
  logic smp;    // Mid-bit sample point
  logic bnd;    // Last clock of a bit
  logic lose;   // Arbitration lost at this sample
  logic match;  // Identifier passes the filter

  // fixed clocks per bit set the rate
  assign smp = (ph == PH_SAMPLE);
  assign bnd = (ph == PH_LAST);
  assign lose = tx_active && smp && (can_tx == REC) &&
                (rx_q == DOM) && (idx <= ARB_END);
  assign match = (((rx_shift[BODY_W-1:DATA_W] ^ acc_id) &
                   acc_mask) == '0);

  // Next-state logic for the whole bit engine
  always_comb begin
    next_st = st;
    next_ph = bnd ? '0 : ph + IDX_ONE;
    next_idx = idx;
    next_tx = can_tx;
    next_txact = tx_active;
    next_shift = tx_shift;
    next_rxs = rx_shift;
    next_lost = 1'b0;
    next_done = 1'b0;
    next_rxv = 1'b0;
    next_rxf = rx_frame;
    buf_pop = 1'b0;
    // Hard sync on any start edge outside a frame
    if (fall && (st != ST_FRAME)) begin
      next_ph = '0;
    end
    case (st)
      ST_WAIT_IDLE: begin
        if (smp) begin
          next_idx = (rx_q == DOM) ? '0 : idx + IDX_ONE;
        end
        // Free only once the last idle bit has fully run out
        if (bnd && (rx_q == REC) && (idx == IDLE_LAST + IDX_ONE)) begin
          next_st = ST_IDLE;
          next_idx = '0;
        end
      end
      ST_IDLE: begin
        if (buf_valid) begin
          next_st = ST_FRAME;
          next_ph = '0;
          next_idx = '0;
          next_tx = DOM;
          next_txact = 1'b1;
          next_shift = buf_data;
        end else if (fall) begin
          // Someone else started; listen
          next_st = ST_FRAME;
          next_idx = '0;
        end
      end
      ST_FRAME: begin
        if (smp) begin
          next_rxs = {rx_shift[FRAME_BITS-2:0], rx_q};
          if (lose) begin
            // no pop, frame stays for retry
            next_txact = 1'b0;
            next_tx = REC;
            next_lost = 1'b1;
          end
        end
        if (bnd) begin
          if (idx == BIT_LAST) begin
            next_st = ST_WAIT_IDLE;
            next_idx = '0;
            next_tx = REC;
            next_txact = 1'b0;
            if (tx_active) begin
              buf_pop = 1'b1;
              next_done = 1'b1;
            end else if (match) begin
              next_rxv = 1'b1;
              next_rxf = rx_shift[BODY_W-1:0];
            end
          end else begin
            next_idx = idx + IDX_ONE;
            if (tx_active) begin
              next_tx = tx_shift[BODY_W-1];
              next_shift = {tx_shift[BODY_W-2:0], REC};
            end
          end
        end
      end
      default: begin
        next_st = ST_WAIT_IDLE;
      end
    endcase
  end

  // Register the bit engine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= ST_WAIT_IDLE;
      ph <= '0;
      idx <= '0;
      can_tx <= REC;
      tx_active <= 1'b0;
      tx_shift <= '0;
      rx_shift <= '0;
      arb_lost <= 1'b0;
      tx_done <= 1'b0;
      rx_valid <= 1'b0;
      rx_frame <= '0;
      bus_idle <= 1'b0;
    end else begin
      st <= next_st;
      ph <= next_ph;
      idx <= next_idx;
      can_tx <= next_tx;
      tx_active <= next_txact;
      tx_shift <= next_shift;
      rx_shift <= next_rxs;
      arb_lost <= next_lost;
      tx_done <= next_done;
      rx_valid <= next_rxv;
      rx_frame <= next_rxf;
      bus_idle <= (next_st == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_lose;
    lose ##1 !tx_active;
  endsequence

  sequence s_start;
    (st == ST_IDLE) && buf_valid ##1 tx_active;
  endsequence

  idle_before_tx_a: assert property (
    $rose(tx_active) |-> $past(st == ST_IDLE))
    else $error("Transmit began without bus idle");

  start_bit_a: assert property (
    s_start |-> (can_tx == DOM) && (idx == '0))
    else $error("Frame did not open with dominant bit");

  lose_release_a: assert property (
    s_lose |-> (can_tx == REC) && arb_lost)
    else $error("Bus not released after lost arbitration");

  winner_keeps_a: assert property (
    tx_active && smp && (can_tx == rx_q) && (idx != BIT_LAST)
      |=> tx_active [*8])
    else $error("Winning frame was cut short");

  pending_hold_a: assert property (
    lose |-> ##1 (buf_valid && !tx_done && st == ST_FRAME))
    else $error("Pending frame dropped on lost arbitration");

  sent_pop_a: assert property (
    tx_active && bnd && (idx == BIT_LAST) |=> tx_done && !tx_active)
    else $error("Completed frame not reported");

  filter_a: assert property (
    rx_valid |-> (((rx_frame.id ^ acc_id) & acc_mask) == '0))
    else $error("Frame delivered despite filter");

  quiet_off_frame_a: assert property (
    (st != ST_FRAME) |-> (can_tx == REC) && !tx_active)
    else $error("Pin driven outside a frame");

  bit_edge_a: assert property (
    $changed(can_tx) && tx_active |-> (ph == '0))
    else $error("Driven bit changed off a bit boundary");

  idle_count_a: assert property (
    (st == ST_WAIT_IDLE) && smp && (rx_q == DOM) |=> (idx == '0))
    else $error("Idle count not restarted by dominant bit");

endmodule

`default_nettype wire

/* sim/cba_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Other node and the shared wire
// ------------------------------------------
module cba_peer (
  // Clock
  input wire logic mclk,
  // Bench command
  input wire logic go,
  input wire logic [18:0] frame,
  // Node pins
  input wire logic can_tx,
  output logic can_rx,
  output logic busy
);
  import cba_pkg::*;
  logic drv; // Level this node drives
  logic [19:0] sh; // Start bit, id, data
  localparam int DOM_LIMIT = 1000; // Clocks before a stuck transmit is cut
  int dom_run = 0; // Unbroken dominant clocks on the node's transmit
  // transceiver cuts off a transmit stuck dominant
  always @(posedge mclk) dom_run <= (can_tx == DOM) ? dom_run + 1 : 0;
  assign can_rx = ((dom_run < DOM_LIMIT) ? can_tx : REC) & drv;
  // One frame per go; drops out like a real node
  initial begin
    drv = REC;
    busy = 1'b0;
    forever begin
      @(posedge mclk);
      if (go === 1'b1) begin
        busy = 1'b1;
        sh = {DOM, frame};
        @(posedge mclk);
        for (int b = 19; b >= 0; b--) begin
          #1 drv = sh[b];
          repeat (12) @(posedge mclk);
          if (drv == REC && can_rx == DOM && b > 7) begin
            break;
          end
          repeat (13) @(posedge mclk);
        end
        #1 drv = REC;
        busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cba_pkg::*;
  // ------------------------------------------
  // Signals and reference queues
  // ------------------------------------------
  logic mclk, rst, tx_valid, tx_ready, rx_valid, tx_done, arb_lost;
  logic bus_idle, can_tx, can_rx, go, peer_busy, ok;
  cba_frame_t tx_frame, rx_frame, peer_frame, f, g;
  logic [ID_W-1:0] acc_id, acc_mask;
  logic [19:0] fr; // Bits decoded off the wire
  int n_fail, checks_done, seed, n_done, n_lost, exp_done, exp_lost;
  int cnt, held;
  cba_frame_t bus_q[$], rx_q[$], exp_bus[$], exp_rx[$];

  cba_node i_cba_node (.mclk(mclk), .rst(rst), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_frame(tx_frame), .acc_id(acc_id),
    .acc_mask(acc_mask), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_done(tx_done), .arb_lost(arb_lost), .bus_idle(bus_idle),
    .can_tx(can_tx), .can_rx(can_rx));
  cba_peer i_cba_peer (.mclk(mclk), .go(go), .frame(peer_frame),
    .can_tx(can_tx), .can_rx(can_rx), .busy(peer_busy));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Pulses and delivered frames
  always @(posedge mclk) begin
    if (arb_lost === 1'b1) begin
      n_lost++;
      chk("can_tx at loss", 20'(REC), 20'(can_tx));
    end
    if (tx_done === 1'b1) n_done++;
    if (rx_valid === 1'b1) rx_q.push_back(rx_frame);
  end

  // Decode every frame on the wire at mid bit
  initial forever begin
    @(negedge can_rx);
    repeat (12) @(posedge mclk);
    for (int b = 19; b >= 0; b--) begin
      fr[b] = can_rx;
      repeat (25) @(posedge mclk);
    end
    chk("start bit", 20'(DOM), 20'(fr[19]));
    bus_q.push_back(fr[18:0]);
  end

  // Offer a frame; valid stays up for the caller
  task automatic send(input cba_frame_t v, input int lim,
                      output logic tk);
    tx_valid = 1'b1;
    tx_frame = v;
    tk = 1'b0;
    for (int i = 0; i < lim && !tk; i++) begin
      @(posedge mclk);
      tk = (tx_ready === 1'b1);
    end
    #1;
    if (tk) exp_bus.push_back(v);
  endtask

  task automatic peer_send(input cba_frame_t v);
    go = 1'b1;
    peer_frame = v;
    @(posedge mclk);
    #1 go = 1'b0;
  endtask

  // Bounded wait for all expected wire traffic and bus free
  task automatic settle();
    cnt = 0;
    while (!(bus_q.size() == exp_bus.size() && bus_idle === 1'b1 &&
             !peer_busy) && cnt < 6000) begin
      @(posedge mclk);
      cnt++;
    end
    #1;
    if (cnt >= 6000) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic compare();
    chk("bus count", 20'(exp_bus.size()), 20'(bus_q.size()));
    chk("rx count", 20'(exp_rx.size()), 20'(rx_q.size()));
    chk("done pulses", 20'(exp_done), 20'(n_done));
    chk("loss pulses", 20'(exp_lost), 20'(n_lost));
    while (exp_bus.size() > 0 && bus_q.size() > 0)
      chk("bus frame", 20'(exp_bus.pop_front()), 20'(bus_q.pop_front()));
    while (exp_rx.size() > 0 && rx_q.size() > 0)
      chk("rx frame", 20'(exp_rx.pop_front()), 20'(rx_q.pop_front()));
    exp_bus.delete();
    exp_rx.delete();
  endtask

  function automatic bit pass(input cba_frame_t v);
    return ((v.id ^ acc_id) & acc_mask) == '0;
  endfunction

  initial begin
    seed = 90978;
    rst = 1'b1;
    tx_valid = 1'b0;
    tx_frame = '0;
    go = 1'b0;
    peer_frame = '0;
    acc_id = '0;
    acc_mask = '0;
    repeat (20) @(posedge mclk);
    chk("reset pins", 20'h30, 20'({can_tx, tx_ready, bus_idle, rx_valid,
      tx_done, arb_lost}));
    #1 rst = 1'b0;
    // Frame offered at once must wait for the idle interval
    f = 19'($random(seed));
    send(f, 5, ok);
    tx_valid = 1'b0;
    exp_done++;
    while (bus_idle !== 1'b1 && can_tx === REC && cnt < 400) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
    chk("idle wait", 20'h1, 20'(cnt >= IDLE_BITS * BIT_CYC - 2 &&
      cnt <= IDLE_BITS * BIT_CYC));
    settle();
    compare();
    // Foreign frames through the filter
    for (int i = 0; i < 6; i++) begin
      f = 19'($random(seed));
      acc_mask = (i < 2) ? '1 : 11'($random(seed));
      acc_id = (i % 2) ? f.id : f.id ^ 11'($random(seed));
      exp_bus.push_back(f);
      if (pass(f)) exp_rx.push_back(f);
      peer_send(f);
      settle();
    end
    compare();
    // Simultaneous starts, lower id wins, the node retries when it loses
    acc_mask = '0;
    for (int i = 0; i < 6; i++) begin
      f = 19'($random(seed));
      g = 19'($random(seed));
      if (i < 2) begin
        f.id = i ? 11'h647 : 11'h6ff;
        g.id = i ? 11'h6ff : 11'h647;
      end
      if (f.id == g.id) g.id = ~f.id;
      tx_valid = 1'b1;
      tx_frame = f;
      peer_send(g);
      tx_valid = 1'b0;
      exp_done++;
      if (f.id < g.id) begin
        exp_bus.push_back(f);
      end else begin
        exp_lost++;
        exp_bus.push_back(g);
        exp_rx.push_back(g);
        exp_bus.push_back(f);
      end
      settle();
    end
    compare();
    // Buffer fills while the bus is taken, then drains in order
    f = 19'($random(seed));
    exp_bus.push_back(f);
    exp_rx.push_back(f);
    peer_send(f);
    // Let the node see the foreign start first, else it would contend
    repeat (BIT_CYC) @(posedge mclk);
    #1;
    ok = 1'b1;
    for (int i = 0; i < 4 && ok; i++) begin
      g = 19'($random(seed));
      send(g, 30, ok);
      if (ok) held++;
    end
    tx_valid = 1'b0;
    exp_done += held;
    chk("frames held", 20'(BUF_DEPTH), 20'(held));
    settle();
    compare();
    // Node reset in mid frame: frame stays on the wire, is not received
    f = 19'($random(seed));
    f.data = '0;
    exp_bus.push_back(f);
    peer_send(f);
    repeat (4 * BIT_CYC) @(posedge mclk);
    #1 rst = 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset pins", 20'h30, 20'({can_tx, tx_ready, bus_idle, rx_valid,
      tx_done, arb_lost}));
    #1 rst = 1'b0;
    settle();
    compare();
    complete_run();
  end
endmodule
`default_nettype wire
